// File: mls_regs.vh
// Register map, field positions and timing constants of the monitor limit block.
// Assumes it is included by bare name from the design files; definitions only.
`ifndef MLS_REGS_VH
`define MLS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MLS_OFS_TEST     8'h15
`define MLS_OFS_VAL0     8'h20
`define MLS_OFS_VAL7     8'h27
`define MLS_OFS_LIM0     8'h2B
`define MLS_OFS_LIM_END  8'h3A
`define MLS_OFS_CFG      8'h40
`define MLS_OFS_STAT1    8'h41
`define MLS_OFS_STAT2    8'h42

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define MLS_CFG_START    0
`define MLS_TEST_THERM   0
`define MLS_TEST_VOLT    1
`define MLS_STAT2_FAULT  6
`define MLS_RST_BYTE     8'h00
`define MLS_NCH          8
`define MLS_CH_REMOTE    3'h6
`define MLS_CH_LOCAL     3'h7
`define MLS_CH_LAST      3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MLS_CLK_MHZ      250
`define MLS_SLOT_US      11600
`define MLS_REM_US       34800
`define MLS_REM_AVG      16
`define MLS_AVG_LAST     4'hF

`endif

// File: mls_lim_mem.v
// Limit store: one high and one low byte per channel, bus port and compare port.
// Assumes one clock; both read ports return data from a register one edge later.
`timescale 1ns/1ns
`include "mls_regs.vh"

module mls_lim_mem (
   input  wire       clk_sys_in,
   input  wire       rst_b_in,
   input  wire       wr_en_in,
   input  wire [2:0] wr_ch_in,
   input  wire       wr_low_in,
   input  wire [7:0] wr_data_in,
   input  wire [2:0] rd_ch_in,
   input  wire       rd_low_in,
   output reg  [7:0] rd_data_out,
   input  wire [2:0] cmp_ch_in,
   output reg  [7:0] cmp_hi_out,
   output reg  [7:0] cmp_lo_out
);

   reg [7:0] hi_q [0:`MLS_NCH-1];
   reg [7:0] lo_q [0:`MLS_NCH-1];
   integer   i;

   // ----------------------------------------------------------------------
   // Storage, cleared at power-up
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (i = 0; i < `MLS_NCH; i = i + 1) begin
            hi_q[i] <= `MLS_RST_BYTE;
            lo_q[i] <= `MLS_RST_BYTE;
         end
         rd_data_out <= `MLS_RST_BYTE;
         cmp_hi_out  <= `MLS_RST_BYTE;
         cmp_lo_out  <= `MLS_RST_BYTE;
      end else begin
         if (wr_en_in && wr_low_in) begin
            lo_q[wr_ch_in] <= wr_data_in;
         end
         if (wr_en_in && !wr_low_in) begin
            hi_q[wr_ch_in] <= wr_data_in;
         end
         rd_data_out <= rd_low_in ? lo_q[rd_ch_in] : hi_q[rd_ch_in];
         cmp_hi_out  <= hi_q[cmp_ch_in];
         cmp_lo_out  <= lo_q[cmp_ch_in];
      end
   end

endmodule

// File: mls_monitor.v
// Round-robin measurement sequencer with value store, limit compare and status.
// Assumes an external converter that holds its result on adc_data_in while the
// selected channel is measured, and a serial bus front end driving the reg port.
//
// What this block does
// - Status register two bit 6 is set on a remote diode fault.
// - Fault covers anode short to ground, to supply, and anode-return short/open.
// - Temperatures are 8-bit two's complement, one degree per code.
// - Remote temperature is the average of 16 successive conversions.
// - A full remote measurement occupies nominally 34.8 ms.
// - Remote bias alternates between base current and N times base.
// - Every channel has its own programmable high and low limit register.
// - On completion the value is stored and compared with its limits at once.
// - Status bit shows only the latest compare: 0 inside, 1 outside limits.
// - Reading a status register never changes any status bit.
// - Writing 1 to configuration bit 0 starts the measurement loop.
// - Channels are measured in turn; each result goes straight to its register.
// - The loop repeats until configuration bit 0 is written 0.
// - Value registers read at any time return the latest completed result.
// - Out-of-limit temperature or voltage can raise an interrupt.
// - Every other channel is converted once per 11.6 ms slot.
// - Interrupt holds until status register one is read, then reasserts if due.
// - With start bit 0 measurement stops, registers stay accessible.
// - Value and limit registers reset to zero; converter idle at power-up.
`timescale 1ns/1ns
`include "mls_regs.vh"

module mls_monitor #(
   parameter [21:0] SLOT_CYC    = `MLS_SLOT_US * `MLS_CLK_MHZ,
   parameter [21:0] REM_SUB_CYC = `MLS_REM_US * `MLS_CLK_MHZ / `MLS_REM_AVG
) (
   input  wire       clk_sys_in,
   input  wire       rst_b_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   output reg        reg_rvalid_out,
   input  wire [7:0] adc_data_in,
   input  wire       diode_short_gnd_in,
   input  wire       diode_short_vcc_in,
   input  wire       diode_pair_bad_in,
   output wire       adc_run_out,
   output wire [2:0] adc_ch_out,
   output wire       bias_high_out,
   output wire       irq_b_out
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_CONV = 2'h1;
   localparam [1:0] ST_CMP  = 2'h2;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function is_temp;
      input [2:0] ch;
      begin
         is_temp = (ch == `MLS_CH_REMOTE) || (ch == `MLS_CH_LOCAL);
      end
   endfunction

   function lim_out;
      input [7:0] val;
      input [7:0] hi;
      input [7:0] lo;
      input       sgn;
      begin
         if (sgn) begin
            lim_out = ($signed(val) > $signed(hi)) || ($signed(val) < $signed(lo));
         end else begin
            lim_out = (val > hi) || (val < lo);
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   reg [7:0] adc_s1_q;
   reg [7:0] adc_s2_q;
   reg [2:0] flt_s1_q;
   reg [2:0] flt_s2_q;

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         adc_s1_q <= `MLS_RST_BYTE;
         adc_s2_q <= `MLS_RST_BYTE;
         flt_s1_q <= 3'h0;
         flt_s2_q <= 3'h0;
      end else begin
         adc_s1_q <= adc_data_in;
         adc_s2_q <= adc_s1_q;
         flt_s1_q <= {diode_pair_bad_in, diode_short_vcc_in, diode_short_gnd_in};
         flt_s2_q <= flt_s1_q;
      end
   end

   // ----------------------------------------------------------------------
   // Register state and bus decode
   // ----------------------------------------------------------------------
   reg  [7:0]  cfg_q;
   reg  [7:0]  test_q;
   reg  [7:0]  stat1_q;
   reg  [7:0]  stat2_q;
   reg  [7:0]  val_q [0:`MLS_NCH-1];
   reg         int_pend_q;
   reg         rd_p1_q;
   reg  [7:0]  addr_p1_q;
   reg  [1:0]  state_q;
   reg  [21:0] tmr_q;
   reg  [2:0]  ch_q;
   reg  [3:0]  sub_q;
   reg  [11:0] acc_q;
   reg  [7:0]  res_q;
   reg         flt_seen_q;
   integer     i;

   wire [7:0]  lim_idx = reg_addr_in - `MLS_OFS_LIM0;
   wire        lim_hit = (reg_addr_in >= `MLS_OFS_LIM0) && (reg_addr_in <= `MLS_OFS_LIM_END);
   wire [7:0]  mem_rdata;
   wire [7:0]  cmp_hi;
   wire [7:0]  cmp_lo;
   wire        start   = cfg_q[`MLS_CFG_START];
   wire        remote  = (ch_q == `MLS_CH_REMOTE);
   wire [21:0] slot_len = remote ? REM_SUB_CYC : SLOT_CYC;
   wire        slot_end = (state_q == ST_CONV) && (tmr_q == slot_len - 22'h1);
   wire [11:0] acc_nx  = acc_q + {{4{adc_s2_q[7]}}, adc_s2_q};
   wire        oor     = lim_out(res_q, cmp_hi, cmp_lo, is_temp(ch_q));
   wire        int_en  = is_temp(ch_q) ? test_q[`MLS_TEST_THERM] : test_q[`MLS_TEST_VOLT];
   wire        int_set = (state_q == ST_CMP) && start && oor && int_en;
   wire        st1_rd  = reg_rd_in && (reg_addr_in == `MLS_OFS_STAT1);

   mls_lim_mem u_lim (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .wr_en_in    (reg_wr_in && lim_hit),
      .wr_ch_in    (lim_idx[3:1]),
      .wr_low_in   (lim_idx[0]),
      .wr_data_in  (reg_wdata_in),
      .rd_ch_in    (lim_idx[3:1]),
      .rd_low_in   (lim_idx[0]),
      .rd_data_out (mem_rdata),
      .cmp_ch_in   (ch_q),
      .cmp_hi_out  (cmp_hi),
      .cmp_lo_out  (cmp_lo)
   );

   // ----------------------------------------------------------------------
   // Bus writes and read pipeline
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_q          <= `MLS_RST_BYTE;
         test_q         <= `MLS_RST_BYTE;
         rd_p1_q        <= 1'b0;
         addr_p1_q      <= `MLS_RST_BYTE;
         reg_rdata_out  <= `MLS_RST_BYTE;
         reg_rvalid_out <= 1'b0;
      end else begin
         if (reg_wr_in && (reg_addr_in == `MLS_OFS_CFG)) begin
            cfg_q <= reg_wdata_in;
         end
         if (reg_wr_in && (reg_addr_in == `MLS_OFS_TEST)) begin
            test_q <= reg_wdata_in;
         end
         rd_p1_q        <= reg_rd_in;
         addr_p1_q      <= reg_addr_in;
         reg_rvalid_out <= rd_p1_q;
         // Reads have no side effect on status; only the interrupt pending bit drops.
         if (rd_p1_q) begin
            if ((addr_p1_q >= `MLS_OFS_VAL0) && (addr_p1_q <= `MLS_OFS_VAL7)) begin
               reg_rdata_out <= val_q[addr_p1_q[2:0]];
            end else if ((addr_p1_q >= `MLS_OFS_LIM0) && (addr_p1_q <= `MLS_OFS_LIM_END)) begin
               reg_rdata_out <= mem_rdata;
            end else if (addr_p1_q == `MLS_OFS_CFG) begin
               reg_rdata_out <= cfg_q;
            end else if (addr_p1_q == `MLS_OFS_TEST) begin
               reg_rdata_out <= test_q;
            end else if (addr_p1_q == `MLS_OFS_STAT1) begin
               reg_rdata_out <= stat1_q;
            end else if (addr_p1_q == `MLS_OFS_STAT2) begin
               reg_rdata_out <= stat2_q;
            end else begin
               reg_rdata_out <= `MLS_RST_BYTE;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q    <= ST_IDLE;
         tmr_q      <= 22'h0;
         ch_q       <= 3'h0;
         sub_q      <= 4'h0;
         acc_q      <= 12'h0;
         res_q      <= `MLS_RST_BYTE;
         flt_seen_q <= 1'b0;
         stat1_q    <= `MLS_RST_BYTE;
         stat2_q    <= `MLS_RST_BYTE;
         int_pend_q <= 1'b0;
         for (i = 0; i < `MLS_NCH; i = i + 1) begin
            val_q[i] <= `MLS_RST_BYTE;
         end
      end else begin
         // A new out-of-limit event wins over a concurrent status read.
         if (int_set) begin
            int_pend_q <= 1'b1;
         end else if (st1_rd) begin
            int_pend_q <= 1'b0;
         end
         if (!start) begin
            state_q    <= ST_IDLE;
            tmr_q      <= 22'h0;
            ch_q       <= 3'h0;
            sub_q      <= 4'h0;
            acc_q      <= 12'h0;
            flt_seen_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q <= ST_CONV;
               end
               ST_CONV: begin
                  if (remote && (flt_s2_q != 3'h0)) begin
                     flt_seen_q <= 1'b1;
                  end
                  if (!slot_end) begin
                     tmr_q <= tmr_q + 22'h1;
                  end else if (!remote) begin
                     res_q   <= adc_s2_q;
                     state_q <= ST_CMP;
                  end else if (sub_q == `MLS_AVG_LAST) begin
                     res_q   <= acc_nx[11:4];
                     state_q <= ST_CMP;
                  end else begin
                     acc_q <= acc_nx;
                     sub_q <= sub_q + 4'h1;
                     tmr_q <= 22'h0;
                  end
               end
               ST_CMP: begin
                  // Value and status change on the same edge, so a read sees both new.
                  val_q[ch_q]   <= res_q;
                  stat1_q[ch_q] <= oor;
                  if (remote) begin
                     stat2_q[`MLS_STAT2_FAULT] <= flt_seen_q;
                  end
                  ch_q       <= (ch_q == `MLS_CH_LAST) ? 3'h0 : ch_q + 3'h1;
                  tmr_q      <= 22'h0;
                  sub_q      <= 4'h0;
                  acc_q      <= 12'h0;
                  flt_seen_q <= 1'b0;
                  state_q    <= ST_CONV;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Converter and bias control
   // ----------------------------------------------------------------------
   assign adc_run_out   = (state_q != ST_IDLE);
   assign adc_ch_out    = ch_q;
   // Second half of each sub-conversion runs the diode at N times base current.
   assign bias_high_out = (state_q == ST_CONV) && remote && (tmr_q >= {1'b0, slot_len[21:1]});
   assign irq_b_out     = ~int_pend_q;

endmodule

// File: mls_monitor_checker.sv
// Checker for the register port and the measurement sequencer outputs.
// Assumes it is bound to mls_monitor and sees only its ports.
`timescale 1ns/1ns
module mls_monitor_checker #(
   parameter [21:0] SLOT_CYC    = 22'h14,
   parameter [21:0] REM_SUB_CYC = 22'h0A
) (
   input wire       clk_sys_in,
   input wire       rst_b_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire       reg_rvalid_out,
   input wire       adc_run_out,
   input wire [2:0] adc_ch_out,
   input wire       bias_high_out,
   input wire       irq_b_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // ------
   // Dwell counters.
   // ------
   // Slot lengths run to millions of cycles, so they are counted, not unrolled.
   reg  [2:0]  ch_q;
   reg  [25:0] dwell_q;
   reg  [25:0] low_q;
   wire        ch_step = adc_run_out && adc_ch_out != ch_q;
   wire        rem_low = adc_run_out && adc_ch_out == 3'h6 && !bias_high_out;
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ch_q    <= 3'h0;
         dwell_q <= 26'h0;
         low_q   <= 26'h0;
      end else begin
         ch_q    <= adc_ch_out;
         dwell_q <= (adc_run_out && !ch_step) ? dwell_q + 26'h1 : 26'h0;
         low_q   <= rem_low ? low_q + 26'h1 : 26'h0;
      end
   end
   // ------
   // Properties.
   // ------
   sequence s_start;
      reg_wr_in && reg_addr_in == 8'h40 && reg_wdata_in[0] && !adc_run_out;
   endsequence
   sequence s_stop;
      reg_wr_in && reg_addr_in == 8'h40 && !reg_wdata_in[0];
   endsequence
   sequence s_st1_rd;
      reg_rd_in && reg_addr_in == 8'h41 && !irq_b_out;
   endsequence
   property p_rd_answer;   reg_rd_in |-> ##2 reg_rvalid_out; endproperty
   property p_rd_cause;    reg_rvalid_out |-> $past(reg_rd_in, 2); endproperty
   property p_rdata_hold;  !reg_rvalid_out |-> $stable(reg_rdata_out); endproperty
   // Start and stop act one edge after the configuration write, seen one edge later.
   property p_start;       s_start |-> ##2 adc_run_out && adc_ch_out == 3'h0; endproperty
   property p_stop;        s_stop |-> ##2 (!adc_run_out && adc_ch_out == 3'h0) [*2]; endproperty
   property p_order;       ch_step |-> adc_ch_out == ch_q + 3'h1; endproperty
   property p_bias_ch;     bias_high_out |-> adc_run_out && adc_ch_out == 3'h6; endproperty
   property p_bias_alt;    low_q <= REM_SUB_CYC; endproperty
   property p_slot;
      ch_step && ch_q != 3'h6 |-> dwell_q >= SLOT_CYC - 2 && dwell_q <= SLOT_CYC + 2;
   endproperty
   property p_remote;
      ch_step && ch_q == 3'h6 |->
         dwell_q >= {REM_SUB_CYC, 4'h0} - 2 && dwell_q <= {REM_SUB_CYC, 4'h0} + 4;
   endproperty
   property p_irq_clear;   s_st1_rd |-> ##[1:3] (irq_b_out || ch_step); endproperty
   property p_irq_src;     $fell(irq_b_out) |-> ch_step || $past(ch_step); endproperty
   a_rd_answer:  assert property (p_rd_answer)  else $error("read not answered");
   a_rd_cause:   assert property (p_rd_cause)   else $error("answer without read");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_start:      assert property (p_start)      else $error("loop did not start");
   a_stop:       assert property (p_stop)       else $error("loop did not stop");
   a_order:      assert property (p_order)      else $error("channel order");
   a_bias_ch:    assert property (p_bias_ch)    else $error("bias off remote");
   a_bias_alt:   assert property (p_bias_alt)   else $error("bias not toggling");
   a_slot:       assert property (p_slot)       else $error("slot length");
   a_remote:     assert property (p_remote)     else $error("remote length");
   a_irq_clear:  assert property (p_irq_clear)  else $error("interrupt kept");
   a_irq_src:    assert property (p_irq_src)    else $error("interrupt source");
endmodule
bind mls_monitor mls_monitor_checker #(
   .SLOT_CYC(SLOT_CYC), .REM_SUB_CYC(REM_SUB_CYC)
) i_chk (
   .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
   .adc_run_out(adc_run_out), .adc_ch_out(adc_ch_out),
   .bias_high_out(bias_high_out), .irq_b_out(irq_b_out)
);

// File: mls_sensor_model.sv
// Model of the converter front end: supply rails and the remote diode.
// Assumes the bench fills chan_val and fault_sel by hierarchical reference.
`timescale 1ns/1ns
module mls_sensor_model (
   input  wire       clk_sys_in,
   input  wire       adc_run_in,
   input  wire [2:0] adc_ch_in,
   output wire [7:0] adc_data_out,
   output wire       short_gnd_out,
   output wire       short_vcc_out,
   output wire       pair_bad_out
);
   reg [7:0] chan_val [0:7];
   reg [2:0] fault_sel;
   reg       tog_q;
   initial begin
      tog_q     = 1'b0;
      fault_sel = 3'h0;
   end
   always @(posedge clk_sys_in) begin
      tog_q <= ~tog_q;
   end
   // An idle converter shows a changing pattern so a stale sample cannot pass.
   assign adc_data_out  = adc_run_in ? chan_val[adc_ch_in] : {8{tog_q}};
   assign short_gnd_out = fault_sel[0];
   assign short_vcc_out = fault_sel[1];
   assign pair_bad_out  = fault_sel[2];
endmodule

// File: mls_monitor_bench.sv
// Self-checking bench for the monitor with a sensor model on the far side.
// Assumes short slot parameters so one loop takes a few hundred cycles.
`timescale 1ns/1ns
module mls_monitor_bench;
   reg         clk_sys_in;
   reg         rst_b_in;
   reg  [7:0]  reg_addr_in;
   reg  [7:0]  reg_wdata_in;
   reg         reg_wr_in;
   reg         reg_rd_in;
   wire [7:0]  reg_rdata_out;
   wire        reg_rvalid_out;
   wire [7:0]  adc_data_in;
   wire        flt_gnd;
   wire        flt_vcc;
   wire        flt_pair;
   wire        adc_run_out;
   wire [2:0]  adc_ch_out;
   wire        bias_high_out;
   wire        irq_b_out;
   integer     err_count;
   integer     check_count;
   integer     i;
   reg  [7:0]  rnd;
   reg  [15:0] note;
   reg  [15:0] exp_q [$];
   reg  [7:0]  v_tab  [0:7] = '{8'h80, 8'hD0, 8'h30, 8'h00, 8'h00, 8'h00, 8'h05, 8'hFB};
   reg  [7:0]  hi_tab [0:7] = '{8'hC0, 8'hC0, 8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'h10, 8'h20};
   reg  [7:0]  lo_tab [0:7] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'hF0, 8'hF6};
   mls_monitor #(.SLOT_CYC(22'h14), .REM_SUB_CYC(22'h0A)) i_dut (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .adc_data_in(adc_data_in), .diode_short_gnd_in(flt_gnd),
      .diode_short_vcc_in(flt_vcc), .diode_pair_bad_in(flt_pair),
      .adc_run_out(adc_run_out), .adc_ch_out(adc_ch_out),
      .bias_high_out(bias_high_out), .irq_b_out(irq_b_out));
   mls_sensor_model i_part (
      .clk_sys_in(clk_sys_in), .adc_run_in(adc_run_out), .adc_ch_in(adc_ch_out),
      .adc_data_out(adc_data_in), .short_gnd_out(flt_gnd),
      .short_vcc_out(flt_vcc), .pair_bad_out(flt_pair));
   function [7:0] lfsr(input [7:0] x);
      lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task chk8(input string nm, input [7:0] e, input [7:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk1(input string nm, input e, input g);
      check_count = check_count + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %s exp %b got %b", nm, e, g);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys_in);
      #1;
      reg_addr_in  = a;
      reg_wdata_in = d;
      reg_wr_in    = 1'b1;
      @(posedge clk_sys_in);
      #1;
      reg_wr_in = 1'b0;
   endtask
   // The expected byte is queued first; the answer watcher pops it.
   task rd(input [7:0] a, input [7:0] e);
      exp_q.push_back({a, e});
      @(posedge clk_sys_in);
      #1;
      reg_addr_in = a;
      reg_rd_in   = 1'b1;
      @(posedge clk_sys_in);
      #1;
      reg_rd_in = 1'b0;
   endtask
   task wait_ch(input [2:0] c);
      integer n;
      n = 0;
      while (adc_ch_out !== c && n < 3000) begin
         @(posedge clk_sys_in);
         n = n + 1;
      end
      if (n >= 3000) begin
         err_count = err_count + 1;
         $display("[ERR] adc_ch_out exp %h got timeout", c);
         final_report;
      end
   endtask
   always @(posedge clk_sys_in) begin
      if (reg_rvalid_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count = err_count + 1;
            $display("[ERR] reg_rdata_out exp none got %h", reg_rdata_out);
         end else begin
            note = exp_q.pop_front();
            chk8($sformatf("reg_rdata_out at %h", note[15:8]), note[7:0], reg_rdata_out);
         end
      end
   end
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      rst_b_in     = 1'b0;
      reg_addr_in  = 8'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in    = 1'b0;
      reg_rd_in    = 1'b0;
      err_count    = 0;
      check_count  = 0;
      rnd          = 8'h3A;
      for (i = 3; i < 6; i = i + 1) begin
         rnd      = lfsr(rnd);
         v_tab[i] = rnd;
      end
      for (i = 0; i < 8; i = i + 1) i_part.chan_val[i] = v_tab[i];
      repeat (6) @(posedge clk_sys_in);
      #1 rst_b_in = 1'b1;
      for (i = 0; i < 16; i = i + 1) rd(8'h2B + i[7:0], 8'h00);
      for (i = 0; i < 8; i = i + 1) rd(8'h20 + i[7:0], 8'h00);
      rd(8'h10, 8'h00);
      wr(8'h20, 8'h5A);
      rd(8'h20, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h2B + {i[6:0], 1'b0}, hi_tab[i]);
         wr(8'h2C + {i[6:0], 1'b0}, lo_tab[i]);
      end
      for (i = 0; i < 8; i = i + 1) begin
         rd(8'h2B + {i[6:0], 1'b0}, hi_tab[i]);
         rd(8'h2C + {i[6:0], 1'b0}, lo_tab[i]);
      end
      wr(8'h15, 8'h03);
      wr(8'h40, 8'h01);
      wait_ch(3'h7);
      wait_ch(3'h0);
      chk1("irq_b_out", 1'b0, irq_b_out);
      rd(8'h41, 8'h06);
      rd(8'h41, 8'h06);
      repeat (3) @(posedge clk_sys_in);
      chk1("irq_b_out", 1'b1, irq_b_out);
      rd(8'h42, 8'h00);
      for (i = 0; i < 8; i = i + 1) rd(8'h20 + i[7:0], v_tab[i]);
      for (i = 1; i < 5; i = i + 1) begin
         wait_ch(3'h7);
         #1;
         i_part.fault_sel = (i < 4) ? 3'h1 << (i - 1) : 3'h0;
         wait_ch(3'h0);
         wait_ch(3'h7);
         rd(8'h42, (i < 4) ? 8'h40 : 8'h00);
      end
      wr(8'h40, 8'h00);
      repeat (2) @(posedge clk_sys_in);
      chk1("adc_run_out", 1'b0, adc_run_out);
      rd(8'h27, v_tab[7]);
      repeat (6) @(posedge clk_sys_in);
      // A read that was never answered must not let the run pass.
      if (exp_q.size() != 0) begin
         err_count = err_count + exp_q.size();
         $display("[ERR] reg_rvalid_out exp %0d more answers got none", exp_q.size());
      end
      final_report;
   end
endmodule
